// File: core/apf_cfg_regs.sv
// AHB-Lite register bank for the audio path filter configuration
`timescale 1ns/1ps
module apf_cfg_regs (
   input wire logic clk, // 10 MHz clock
   input wire logic srst, // Synchronous reset, active high
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size
   input wire logic hready, // Bus ready
   input wire logic [31:0] hwdata, // Write data
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   output logic [31:0] trim_level, // Full-scale reference
   output logic [15:0] harm2_coef, // Second harmonic coefficient
   output logic [15:0] harm3_coef, // Third harmonic coefficient
   output logic coef_ram_we, // RAM write strobe, one cycle
   output logic coef_ram_stage, // 0 first stage, 1 second
   output logic [7:0] coef_ram_addr, // Coefficient location 0-255
   output logic [31:0] coef_ram_data, // Coefficient value
   output logic osf_bypass, // Skip internal interpolator
   output logic first_stage_long, // 256-tap first stage
   output logic os_off_ch3_8, // Oversampling off on channels 3-8
   output logic second_stage_symmetry, // 0 sine 27, 1 cosine 28
   output logic custom_coef_en, // Use RAM coefficients
   output logic [31:0] dac_source_select // Nibble n-1 is DAC n source
);

   logic [31:0] full_scale_reference_level;
   logic [15:0] second_harmonic_correction;
   logic [15:0] third_harmonic_correction;
   logic [7:0] filter_coefficient_pointer;
   logic [31:0] filter_coefficient_value;
   logic [7:0] oversampling_filter_setup;
   logic [7:0] dac_pair_1_2_source_select;
   logic [7:0] dac_pair_3_4_source_select;
   logic [7:0] dac_pair_5_6_source_select;
   logic [7:0] dac_pair_7_8_source_select;
   logic path_mode_stereo;
   logic [7:0] last_ram_addr;
   logic last_ram_stage;
   logic [15:0] ram_write_count;
   logic wr_pend;
   logic rd_pend;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic wr_commit;
   logic take;
   logic [31:0] next_rdata;
   logic [31:0] next_route;

   assign take = hsel && hready && (htrans == apf_cfg_pkg::HTRANS_NONSEQ);
   assign wr_commit = wr_pend;

   // Address phase capture
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
      end else begin
         wr_pend <= take && hwrite;
         if (take && hwrite) begin
            wr_idx <= haddr[9:2];
         end
      end
   end

   // Reads take one wait state so writes before them have landed
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_pend <= 1'b0;
         rd_idx <= 8'h00;
         hreadyout <= 1'b1;
         hrdata <= 32'h00000000;
      end else begin
         rd_pend <= take && !hwrite;
         hreadyout <= !(take && !hwrite);
         if (take && !hwrite) begin
            rd_idx <= haddr[9:2];
         end
         if (rd_pend) begin
            hrdata <= next_rdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hresp <= apf_cfg_pkg::HRESP_OKAY;
      end else begin
         hresp <= apf_cfg_pkg::HRESP_OKAY;
      end
   end

   // Read mux; unmapped indices read zero
   always_comb begin
      next_rdata = 32'h00000000;
      case (rd_idx)
         apf_cfg_pkg::IDX_TRIM: next_rdata = full_scale_reference_level;
         apf_cfg_pkg::IDX_C2: next_rdata = {16'h0000, second_harmonic_correction};
         apf_cfg_pkg::IDX_C3: next_rdata = {16'h0000, third_harmonic_correction};
         apf_cfg_pkg::IDX_PTR: next_rdata = {24'h000000, filter_coefficient_pointer};
         apf_cfg_pkg::IDX_VAL: next_rdata = filter_coefficient_value;
         apf_cfg_pkg::IDX_SETUP: next_rdata = {24'h000000, oversampling_filter_setup};
         apf_cfg_pkg::IDX_MAP12: next_rdata = {24'h000000, dac_pair_1_2_source_select};
         apf_cfg_pkg::IDX_MAP34: next_rdata = {24'h000000, dac_pair_3_4_source_select};
         apf_cfg_pkg::IDX_MAP56: next_rdata = {24'h000000, dac_pair_5_6_source_select};
         apf_cfg_pkg::IDX_MAP78: next_rdata = {24'h000000, dac_pair_7_8_source_select};
         apf_cfg_pkg::IDX_MODE: next_rdata = {31'h0, path_mode_stereo};
         apf_cfg_pkg::IDX_STAT: next_rdata = {ram_write_count, 7'h00, last_ram_stage,
            last_ram_addr};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // Level and correction words
   always_ff @(posedge clk) begin
      if (srst) begin
         full_scale_reference_level <= apf_cfg_pkg::RST_TRIM;
         second_harmonic_correction <= apf_cfg_pkg::RST_C2;
         third_harmonic_correction <= apf_cfg_pkg::RST_C3;
      end else if (wr_commit) begin
         if (wr_idx == apf_cfg_pkg::IDX_TRIM) begin
            full_scale_reference_level <= hwdata;
         end
         if (wr_idx == apf_cfg_pkg::IDX_C2) begin
            second_harmonic_correction <= hwdata[15:0];
         end
         if (wr_idx == apf_cfg_pkg::IDX_C3) begin
            third_harmonic_correction <= hwdata[15:0];
         end
      end
   end

   // Coefficient pointer and value
   always_ff @(posedge clk) begin
      if (srst) begin
         filter_coefficient_pointer <= apf_cfg_pkg::RST_PTR;
         filter_coefficient_value <= apf_cfg_pkg::RST_VAL;
      end else if (wr_commit) begin
         if (wr_idx == apf_cfg_pkg::IDX_PTR) begin
            filter_coefficient_pointer <= hwdata[7:0];
         end
         if (wr_idx == apf_cfg_pkg::IDX_VAL) begin
            filter_coefficient_value <= hwdata;
         end
      end
   end

   // Filter options; reserved bits 6:5 stay zero
   always_ff @(posedge clk) begin
      if (srst) begin
         oversampling_filter_setup <= apf_cfg_pkg::RST_SETUP;
      end else if (wr_commit && wr_idx == apf_cfg_pkg::IDX_SETUP) begin
         oversampling_filter_setup <= hwdata[7:0] & apf_cfg_pkg::SETUP_MASK;
      end
   end

   // Routing selectors and stereo mode
   always_ff @(posedge clk) begin
      if (srst) begin
         dac_pair_1_2_source_select <= apf_cfg_pkg::RST_MAP12;
         dac_pair_3_4_source_select <= apf_cfg_pkg::RST_MAP34;
         dac_pair_5_6_source_select <= apf_cfg_pkg::RST_MAP56;
         dac_pair_7_8_source_select <= apf_cfg_pkg::RST_MAP78;
         path_mode_stereo <= 1'b0;
      end else if (wr_commit) begin
         case (wr_idx)
            apf_cfg_pkg::IDX_MAP12: dac_pair_1_2_source_select <= hwdata[7:0];
            apf_cfg_pkg::IDX_MAP34: dac_pair_3_4_source_select <= hwdata[7:0];
            apf_cfg_pkg::IDX_MAP56: dac_pair_5_6_source_select <= hwdata[7:0];
            apf_cfg_pkg::IDX_MAP78: dac_pair_7_8_source_select <= hwdata[7:0];
            apf_cfg_pkg::IDX_MODE: path_mode_stereo <= hwdata[apf_cfg_pkg::MODE_STEREO];
            default: path_mode_stereo <= path_mode_stereo;
         endcase
      end
   end

   // Coefficient RAM port: writing the value word fires one strobe while the write-enable bit is set
   always_ff @(posedge clk) begin
      if (srst) begin
         coef_ram_we <= 1'b0;
         coef_ram_stage <= 1'b0;
         coef_ram_addr <= 8'h00;
         coef_ram_data <= 32'h00000000;
      end else begin
         coef_ram_we <= wr_commit && wr_idx == apf_cfg_pkg::IDX_VAL &&
            oversampling_filter_setup[apf_cfg_pkg::SET_WE];
         if (wr_commit && wr_idx == apf_cfg_pkg::IDX_VAL) begin
            coef_ram_stage <= filter_coefficient_pointer[apf_cfg_pkg::PTR_STAGE];
            coef_ram_addr <= {oversampling_filter_setup[apf_cfg_pkg::SET_EXT],
               filter_coefficient_pointer[6:0]};
            coef_ram_data <= hwdata;
         end
      end
   end

   // Record of RAM writes for software
   always_ff @(posedge clk) begin
      if (srst) begin
         last_ram_addr <= 8'h00;
         last_ram_stage <= 1'b0;
         ram_write_count <= 16'h0000;
      end else if (coef_ram_we) begin
         last_ram_addr <= coef_ram_addr;
         last_ram_stage <= coef_ram_stage;
         ram_write_count <= ram_write_count + 16'h0001;
      end
   end

   // Mode outputs mirror the setup register
   always_ff @(posedge clk) begin
      if (srst) begin
         osf_bypass <= 1'b0;
         first_stage_long <= 1'b0;
         os_off_ch3_8 <= 1'b0;
         second_stage_symmetry <= 1'b0;
         custom_coef_en <= 1'b0;
      end else begin
         osf_bypass <= oversampling_filter_setup[apf_cfg_pkg::SET_BYPASS];
         first_stage_long <= oversampling_filter_setup[apf_cfg_pkg::SET_LONG];
         os_off_ch3_8 <= oversampling_filter_setup[apf_cfg_pkg::SET_LONG];
         second_stage_symmetry <= oversampling_filter_setup[apf_cfg_pkg::SET_SYM];
         custom_coef_en <= oversampling_filter_setup[apf_cfg_pkg::SET_CUSTOM];
      end
   end

   // Effective routing; stereo overrides the selectors
   always_comb begin
      next_route = {dac_pair_7_8_source_select, dac_pair_5_6_source_select,
         dac_pair_3_4_source_select, dac_pair_1_2_source_select};
      if (path_mode_stereo) begin
         next_route = {4{apf_cfg_pkg::SRC_IN2, apf_cfg_pkg::SRC_IN1}};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         trim_level <= apf_cfg_pkg::RST_TRIM;
         harm2_coef <= apf_cfg_pkg::RST_C2;
         harm3_coef <= apf_cfg_pkg::RST_C3;
         dac_source_select <= {apf_cfg_pkg::RST_MAP78, apf_cfg_pkg::RST_MAP56,
            apf_cfg_pkg::RST_MAP34, apf_cfg_pkg::RST_MAP12};
      end else begin
         trim_level <= full_scale_reference_level;
         harm2_coef <= second_harmonic_correction;
         harm3_coef <= third_harmonic_correction;
         dac_source_select <= next_route;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_val_write_enabled;
      wr_commit && wr_idx == apf_cfg_pkg::IDX_VAL &&
         oversampling_filter_setup[apf_cfg_pkg::SET_WE];
   endsequence

   sequence s_read_taken;
      take && !hwrite;
   endsequence

   a_trim_after_reset: assert property (
      $fell(srst) |-> full_scale_reference_level == 32'h07ffffff ##1
         trim_level == 32'h07ffffff)
      else $error("trim word not at full scale after reset");

   a_harm2_write: assert property (
      wr_commit && wr_idx == apf_cfg_pkg::IDX_C2 |-> ##2 harm2_coef == $past(hwdata[15:0], 2))
      else $error("second harmonic word not updated");

   a_harm3_write: assert property (
      wr_commit && wr_idx == apf_cfg_pkg::IDX_C3 |-> ##2 harm3_coef == $past(hwdata[15:0], 2))
      else $error("third harmonic word not updated");

   a_ram_strobe_fire: assert property (
      s_val_write_enabled |=> coef_ram_we && coef_ram_data == $past(hwdata) ##1 !coef_ram_we)
      else $error("value write did not give one strobe with its data");

   a_ram_protect: assert property (
      coef_ram_we |-> $past(oversampling_filter_setup[1]) && $past(wr_idx) == 8'h21)
      else $error("RAM strobe without write enable");

   a_ram_addr_map: assert property (
      s_val_write_enabled |=> coef_ram_addr == {$past(oversampling_filter_setup[3]),
         $past(filter_coefficient_pointer[6:0])} &&
         coef_ram_stage == $past(filter_coefficient_pointer[7]))
      else $error("RAM address or stage wrong");

   a_long_filter_off: assert property (
      oversampling_filter_setup[4] [*2] |-> first_stage_long && os_off_ch3_8)
      else $error("long filter not signalled");

   a_bypass_follow: assert property (
      $rose(oversampling_filter_setup[7]) |=> osf_bypass && custom_coef_en ==
         $past(oversampling_filter_setup[0]))
      else $error("bypass output does not follow setup");

   a_sym_follow: assert property (
      ##1 second_stage_symmetry == $past(oversampling_filter_setup[2]))
      else $error("symmetry output does not follow setup");

   a_stereo_route: assert property (
      path_mode_stereo [*2] |-> dac_source_select == 32'h10101010)
      else $error("stereo routing wrong");

   a_normal_route: assert property (
      !path_mode_stereo ##1 !path_mode_stereo |-> dac_source_select[3:0] ==
         $past(dac_pair_1_2_source_select[3:0]) && dac_source_select[7:4] ==
         $past(dac_pair_1_2_source_select[7:4]))
      else $error("selector nibbles misplaced");

   a_read_wait: assert property (
      s_read_taken |=> !hreadyout ##1 hreadyout && hresp == 1'b0)
      else $error("read answer timing wrong");

   a_trim_write: assert property (
      wr_commit && wr_idx == apf_cfg_pkg::IDX_TRIM |-> ##2 trim_level == $past(hwdata, 2))
      else $error("trim word not updated");

   a_pointer_write: assert property (
      wr_commit && wr_idx == apf_cfg_pkg::IDX_PTR |=>
         filter_coefficient_pointer == $past(hwdata[7:0]))
      else $error("coefficient pointer not updated");

   a_value_write: assert property (
      wr_commit && wr_idx == apf_cfg_pkg::IDX_VAL |=>
         filter_coefficient_value == $past(hwdata))
      else $error("coefficient value not updated");

   a_custom_follow: assert property (
      ##1 custom_coef_en == $past(oversampling_filter_setup[apf_cfg_pkg::SET_CUSTOM]))
      else $error("custom enable output does not follow setup");

   a_short_filter: assert property (
      (!oversampling_filter_setup[apf_cfg_pkg::SET_LONG]) [*2] |-> !first_stage_long &&
         !os_off_ch3_8)
      else $error("short filter not signalled");

   a_reset_route: assert property (
      $fell(srst) |-> dac_source_select == 32'h76543210)
      else $error("routing not identity after reset");

   a_write_no_wait: assert property (
      wr_pend |-> hreadyout)
      else $error("write data phase was stretched");

   a_status_count: assert property (
      coef_ram_we |=> ram_write_count == $past(ram_write_count) + 16'h0001)
      else $error("RAM write count did not step");

endmodule // apf_cfg_regs

// File: core/apf_cfg_pkg.sv
// Constants for the audio path filter configuration register bank
// Functional notes
// - 32-bit signed full-scale trim word, resets to 32'h7ffffff.
// - 16-bit signed second-harmonic correction coefficient, resets to zero.
// - 16-bit signed third-harmonic correction coefficient, resets to zero.
// - Pointer bit 7 picks coefficient stage: 0 first (reset), 1 second.
// - Pointer bits 6:0 pick the coefficient location to write.
// - 32-bit value register, reset zero, stored at the pointed location.
// - Bypass bit skips internal interpolator; source then supplies 8x data.
// - Length bit: 128 taps when clear, 256 taps and channels 3-8 off.
// - Extended bit moves pointer range from 0-127 to 128-255.
// - Symmetry bit: sine 27 coefficients clear, cosine 28 set.
// - RAM write strobe only while write-enable bit is one.
// - Custom-enable bit picks RAM coefficients instead of built-in shape.
// - Each DAC has a 4-bit source code, 0 input one to 7 input eight.
// - Two selectors per byte, odd DAC low nibble; reset is identity.
// - Stereo mode feeds input one to odd DACs, input two to even.
package apf_cfg_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_TRIM = 8'h18;
   localparam logic [7:0] IDX_C2 = 8'h1c;
   localparam logic [7:0] IDX_C3 = 8'h1e;
   localparam logic [7:0] IDX_PTR = 8'h20;
   localparam logic [7:0] IDX_VAL = 8'h21;
   localparam logic [7:0] IDX_SETUP = 8'h25;
   localparam logic [7:0] IDX_MAP12 = 8'h26;
   localparam logic [7:0] IDX_MAP34 = 8'h27;
   localparam logic [7:0] IDX_MAP56 = 8'h28;
   localparam logic [7:0] IDX_MAP78 = 8'h29;
   localparam logic [7:0] IDX_MODE = 8'h30;
   localparam logic [7:0] IDX_STAT = 8'h31;
   // Reset values
   localparam logic [31:0] RST_TRIM = 32'h07ffffff;
   localparam logic [15:0] RST_C2 = 16'h0000;
   localparam logic [15:0] RST_C3 = 16'h0000;
   localparam logic [7:0] RST_PTR = 8'h00;
   localparam logic [31:0] RST_VAL = 32'h00000000;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [7:0] RST_MAP12 = 8'h10;
   localparam logic [7:0] RST_MAP34 = 8'h32;
   localparam logic [7:0] RST_MAP56 = 8'h54;
   localparam logic [7:0] RST_MAP78 = 8'h76;
   // Field positions
   localparam int PTR_STAGE = 7;
   localparam int SET_BYPASS = 7;
   localparam int SET_LONG = 4;
   localparam int SET_EXT = 3;
   localparam int SET_SYM = 2;
   localparam int SET_WE = 1;
   localparam int SET_CUSTOM = 0;
   localparam logic [7:0] SETUP_MASK = 8'h9f;
   localparam int MODE_STEREO = 0;
   // Routing codes in stereo mode
   localparam logic [3:0] SRC_IN1 = 4'h0;
   localparam logic [3:0] SRC_IN2 = 4'h1;
   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
endpackage

// File: test/audio_path_filter_config_regs_bench.sv
// Self-checking bench for the audio path filter configuration register bank
`timescale 1ns/1ps
module audio_path_filter_config_regs_bench;
   logic clk;
   logic srst;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic hready;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] trim_level;
   logic [15:0] harm2_coef;
   logic [15:0] harm3_coef;
   logic coef_ram_we;
   logic coef_ram_stage;
   logic [7:0] coef_ram_addr;
   logic [31:0] coef_ram_data;
   logic osf_bypass, first_stage_long, os_off_ch3_8, second_stage_symmetry, custom_coef_en;
   logic [31:0] dac_source_select;
   int error_cnt = 0;
   int samples_checked = 0;
   int strobe_cnt = 0;
   logic [40:0] strobe_seen = '0;

   // Single slave: its ready is the bus ready
   assign hready = hreadyout;

   apf_cfg_regs dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .trim_level(trim_level), .harm2_coef(harm2_coef),
      .harm3_coef(harm3_coef), .coef_ram_we(coef_ram_we), .coef_ram_stage(coef_ram_stage),
      .coef_ram_addr(coef_ram_addr), .coef_ram_data(coef_ram_data), .osf_bypass(osf_bypass),
      .first_stage_long(first_stage_long), .os_off_ch3_8(os_off_ch3_8),
      .second_stage_symmetry(second_stage_symmetry), .custom_coef_en(custom_coef_en),
      .dac_source_select(dac_source_select));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Counts strobe cycles and keeps what the last one carried
   always @(posedge clk) begin
      if (coef_ram_we === 1'b1) begin
         strobe_cnt <= strobe_cnt + 1;
         strobe_seen <= {coef_ram_stage, coef_ram_addr, coef_ram_data};
      end
   end

   task automatic end_sim;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [40:0] seen, input logic [40:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         error_cnt++;
         $display("wrong value at %0t: bus never ready", $time);
         end_sim;
      end
   endtask

   task automatic bus_xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                           output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= apf_cfg_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready;
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] unused;
      bus_xfer(idx, 1'b1, wd, unused);
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      bus_xfer(idx, 1'b0, 32'h0, d);
      check(d, exp);
      check(hresp, apf_cfg_pkg::HRESP_OKAY);
   endtask

   task automatic settle;
      repeat (3) @(posedge clk);
   endtask

   task automatic test_reset;
      rd_chk(apf_cfg_pkg::IDX_TRIM, 32'h07ffffff);
      rd_chk(apf_cfg_pkg::IDX_C2, 32'h0);
      rd_chk(apf_cfg_pkg::IDX_C3, 32'h0);
      rd_chk(apf_cfg_pkg::IDX_PTR, 32'h0);
      rd_chk(apf_cfg_pkg::IDX_VAL, 32'h0);
      rd_chk(apf_cfg_pkg::IDX_SETUP, 32'h0);
      rd_chk(apf_cfg_pkg::IDX_MAP12, 32'h10);
      rd_chk(apf_cfg_pkg::IDX_MAP78, 32'h76);
      check(trim_level, 32'h07ffffff);
      check(dac_source_select, 32'h76543210);
      check({osf_bypass, first_stage_long, os_off_ch3_8, second_stage_symmetry,
             custom_coef_en, coef_ram_we}, 6'h00);
   endtask

   task automatic test_trim_harm;
      wr(apf_cfg_pkg::IDX_TRIM, 32'h80000001);
      wr(apf_cfg_pkg::IDX_C2, 32'h00008001);
      wr(apf_cfg_pkg::IDX_C3, 32'h00007fff);
      rd_chk(apf_cfg_pkg::IDX_TRIM, 32'h80000001);
      rd_chk(apf_cfg_pkg::IDX_C2, 32'h00008001);
      rd_chk(apf_cfg_pkg::IDX_C3, 32'h00007fff);
      settle;
      check({trim_level, harm2_coef}, {32'h80000001, 16'h8001});
      check(harm3_coef, 16'h7fff);
   endtask

   task automatic test_setup;
      logic [7:0] v [7] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'hff};
      wr(apf_cfg_pkg::IDX_MODE, 32'h1);
      rd_chk(apf_cfg_pkg::IDX_MODE, 32'h1);
      for (int i = 0; i < 7; i++) begin
         wr(apf_cfg_pkg::IDX_SETUP, {24'h0, v[i]});
         rd_chk(apf_cfg_pkg::IDX_SETUP, {24'h0, v[i] & 8'h9f});
         settle;
         check({osf_bypass, first_stage_long, os_off_ch3_8, second_stage_symmetry,
                custom_coef_en}, {v[i][7], v[i][4], v[i][4], v[i][2], v[i][0]});
         check(coef_ram_we, 1'b0);
      end
      wr(apf_cfg_pkg::IDX_SETUP, 32'h0);
      wr(apf_cfg_pkg::IDX_MODE, 32'h0);
   endtask

   task automatic test_ram;
      int base;
      wr(apf_cfg_pkg::IDX_PTR, 32'h85);
      base = strobe_cnt;
      wr(apf_cfg_pkg::IDX_VAL, 32'hdeadbeef);
      rd_chk(apf_cfg_pkg::IDX_VAL, 32'hdeadbeef);
      rd_chk(apf_cfg_pkg::IDX_PTR, 32'h85);
      settle;
      check(strobe_cnt - base, 41'd0);
      wr(apf_cfg_pkg::IDX_SETUP, 32'h0a);
      wr(apf_cfg_pkg::IDX_VAL, 32'h80000007);
      settle;
      check(strobe_cnt - base, 41'd1);
      check(strobe_seen, {1'b1, 8'h85, 32'h80000007});
      wr(apf_cfg_pkg::IDX_SETUP, 32'h02);
      wr(apf_cfg_pkg::IDX_PTR, 32'h7f);
      wr(apf_cfg_pkg::IDX_VAL, 32'h00000011);
      wr(apf_cfg_pkg::IDX_VAL, 32'h00000022);
      settle;
      check(strobe_cnt - base, 41'd3);
      check(strobe_seen, {1'b0, 8'h7f, 32'h00000022});
      rd_chk(apf_cfg_pkg::IDX_STAT, {16'h0003, 7'h00, 1'b0, 8'h7f});
      wr(apf_cfg_pkg::IDX_SETUP, 32'h0);
   endtask

   task automatic test_map;
      wr(apf_cfg_pkg::IDX_MAP12, 32'h67);
      wr(apf_cfg_pkg::IDX_MAP34, 32'h45);
      wr(apf_cfg_pkg::IDX_MAP56, 32'h23);
      wr(apf_cfg_pkg::IDX_MAP78, 32'h01);
      rd_chk(apf_cfg_pkg::IDX_MAP34, 32'h45);
      settle;
      check(dac_source_select, 32'h01234567);
      wr(apf_cfg_pkg::IDX_MODE, 32'h1);
      settle;
      check(dac_source_select, 32'h10101010);
      rd_chk(apf_cfg_pkg::IDX_MAP12, 32'h67);
      wr(apf_cfg_pkg::IDX_MODE, 32'h0);
      settle;
      check(dac_source_select, 32'h01234567);
   endtask

   task automatic test_unmapped;
      wr(8'h40, 32'h12345678);
      rd_chk(8'h40, 32'h0);
      rd_chk(apf_cfg_pkg::IDX_TRIM, 32'h80000001);
   endtask

   initial begin
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      test_reset;
      test_trim_harm;
      test_setup;
      test_ram;
      test_map;
      test_unmapped;
      end_sim;
   end
endmodule // audio_path_filter_config_regs_bench
